// ---- design/ddac_params.svh ----
// constants for the dual converter serial front end
`ifndef DDAC_PARAMS_SVH
`define DDAC_PARAMS_SVH
`define DDAC_WORD_BITS 24
`define DDAC_CNT_W 5
`define DDAC_LAST_BIT 5'h17
`define DDAC_CODE_W 16
`define DDAC_ZERO_CODE 16'h0000
`define DDAC_CMD_MSB 21
`define DDAC_CMD_LSB 19
`define DDAC_ADDR_MSB 18
`define DDAC_ADDR_LSB 16
`define DDAC_CMD_WR_IN 3'h0
`define DDAC_CMD_UPD 3'h1
`define DDAC_CMD_WR_IN_UPD_ALL 3'h2
`define DDAC_CMD_WR_UPD 3'h3
`define DDAC_CMD_REF 3'h7
`define DDAC_ADDR_A 3'h0
`define DDAC_ADDR_B 3'h1
`define DDAC_ADDR_ALL 3'h7
`endif

// ---- design/ddac_pkg.sv ----
// types for the dual converter serial front end
package ddac_pkg;
	typedef enum logic [1:0] {
		DDAC_IDLE = 2'b00,
		DDAC_SHIFT = 2'b01,
		DDAC_DONE = 2'b10
	} ddac_state_t;
endpackage : ddac_pkg

// ---- design/ddac_sync.sv ----
// two flip-flop synchroniser plus edge detection for the frame select, serial clock, load and clear pins
`timescale 1ns/100ps
`default_nettype none
module ddac_sync
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] pin,
	output logic [3:0] level,
	output logic [3:0] rise,
	output logic [3:0] fall
);
	logic [3:0] meta;
	logic [3:0] prev;

	// only the second stage and later are read by logic
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			meta <= 4'hf;
			level <= 4'hf;
			prev <= 4'hf;
		end
		else
		begin
			meta <= pin;
			level <= meta;
			prev <= level;
		end
	end

	// edges found between the second and third stage
	always_comb
	begin
		rise = level & ~prev;
		fall = ~level & prev;
	end
endmodule : ddac_sync
`default_nettype wire

// ---- design/ddac_core.sv ----
// serial load, update strobe and clear logic of the dual converter
`timescale 1ns/100ps
`default_nettype none
`include "ddac_params.svh"

// Contract
// RQ1 - shift only while frame select low
// RQ2 - sample data on serial clock falling edge
// RQ3 - shift register exactly 24 bits
// RQ4 - act on word after 24th edge
// RQ5 - early frame select rise discards word
// RQ6 - host clock at most 50 MHz
// RQ7 - load strobe low copies pending inputs
// RQ8 - load strobe tied low is valid
// RQ9 - clear triggers on its falling edge
// RQ10 - load strobe ignored while clear low
// RQ11 - clear zeroes all input and output registers
// RQ12 - clear mode ends at next 24th edge
// RQ13 - clear during frame aborts the write
// RQ14 - reference pin input after power up
// RQ15 - codes are straight unsigned binary
// RQ16 - decode command, address, data fields
// RQ17 - bit counter zeroed at frame start
// RQ18 - host sends msb first, frame held low
module ddac_core
	import ddac_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// serial link from the host
	input wire logic frame_sel_n,
	input wire logic serial_clk,
	input wire logic serial_data,
	// hardware strobes
	input wire logic load_outputs_n,
	input wire logic async_clear_n,
	// converter codes, straight binary
	output logic [`DDAC_CODE_W-1:0] channel_a_out,
	output logic [`DDAC_CODE_W-1:0] channel_b_out,
	// status
	output logic clear_mode,
	output logic internal_ref_on,
	output logic reference_pin_oe
);
	// ************************************************
	// pin synchronisation
	// ************************************************
	logic [3:0] s_level;
	logic [3:0] s_fall;
	logic data_meta;
	logic data_sync;
	logic sclk_fall;
	logic fs_low;
	logic fs_fall;
	logic ld_low;
	logic clr_fall;
	logic clr_low;

	// the host clock runs slower than ours here; at full 50 MHz a faster sampling clock is needed [RQ6]
	ddac_sync u_sync
	(
		.clock(clock),
		.rst(rst),
		.pin({async_clear_n, load_outputs_n, serial_clk, frame_sel_n}),
		.level(s_level),
		.rise(),
		.fall(s_fall)
	);

	// serial data gets its own two stages so it lines up with the delayed clock edge
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			data_meta <= 1'b0;
			data_sync <= 1'b0;
		end
		else
		begin
			data_meta <= serial_data;
			data_sync <= data_meta;
		end
	end

	assign fs_low = ~s_level[0];
	assign fs_fall = s_fall[0];
	assign sclk_fall = s_fall[1];
	assign ld_low = ~s_level[2];
	assign clr_low = ~s_level[3];
	assign clr_fall = s_fall[3];

	// ************************************************
	// shift register and frame control
	// ************************************************
	ddac_state_t state;
	logic [`DDAC_WORD_BITS-1:0] shift; // exactly 24 bits [RQ3]
	logic [`DDAC_CNT_W-1:0] bit_cnt;
	logic word_ok;

	// frame state; abort on early rise or on clear
	always_ff @(posedge clock)
	begin
		if (rst)
			state <= DDAC_IDLE;
		else
		begin
			case (state)
				DDAC_IDLE:
					if (fs_low && clr_fall)
						state <= DDAC_DONE; // clear at frame start also kills it [RQ13]
					else if (fs_low)
						state <= DDAC_SHIFT; // [RQ1]
				DDAC_SHIFT:
					if (clr_fall)
						state <= DDAC_DONE; // clear kills the frame [RQ13]
					else if (!fs_low)
						state <= DDAC_IDLE; // early rise, word dropped [RQ5]
					else if (sclk_fall && bit_cnt == `DDAC_LAST_BIT)
						state <= DDAC_DONE;
				DDAC_DONE:
					if (!fs_low)
						state <= DDAC_IDLE; // extra clocks ignored until frame ends
				default:
					state <= DDAC_IDLE;
			endcase
		end
	end

	// msb first shifting on serial clock falling edges [RQ2] [RQ18]
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			shift <= 24'h000000;
			bit_cnt <= 5'h00;
		end
		else if (state == DDAC_IDLE)
			bit_cnt <= 5'h00; // each frame restarts at bit zero [RQ17]
		else if (state == DDAC_SHIFT && fs_low && sclk_fall)
		begin
			shift <= {shift[`DDAC_WORD_BITS-2:0], data_sync};
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// one-cycle strobe once the 24th edge lands [RQ4]
	always_ff @(posedge clock)
	begin
		if (rst)
			word_ok <= 1'b0;
		else
			word_ok <= state == DDAC_SHIFT && fs_low && !clr_fall && sclk_fall && bit_cnt == `DDAC_LAST_BIT;
	end

	// ************************************************
	// word decode
	// ************************************************
	logic [2:0] cmd;
	logic [2:0] addr;
	logic [`DDAC_CODE_W-1:0] code;
	logic sel_a;
	logic sel_b;
	// shift is stable while word_ok is high: the frame is in done state [RQ16]
	assign cmd = shift[`DDAC_CMD_MSB:`DDAC_CMD_LSB];
	assign addr = shift[`DDAC_ADDR_MSB:`DDAC_ADDR_LSB];
	assign code = shift[`DDAC_CODE_W-1:0];
	assign sel_a = addr == `DDAC_ADDR_A || addr == `DDAC_ADDR_ALL;
	assign sel_b = addr == `DDAC_ADDR_B || addr == `DDAC_ADDR_ALL;

	// ************************************************
	// input and output registers, per channel
	// ************************************************
	logic [`DDAC_CODE_W-1:0] in_reg [2];
	logic [`DDAC_CODE_W-1:0] dac_reg [2];
	logic pending [2];
	logic ld_ok;
	// a low level rather than an edge, so a tied-low strobe loads continuously [RQ7] [RQ8]
	assign ld_ok = ld_low && !clr_low; // [RQ10]

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			logic sel;
			logic wr_in;
			logic upd;
			assign sel = (ch == 0) ? sel_a : sel_b;
			assign wr_in = word_ok && sel && (cmd == `DDAC_CMD_WR_IN || cmd == `DDAC_CMD_WR_IN_UPD_ALL
				|| cmd == `DDAC_CMD_WR_UPD);
			assign upd = word_ok && ((sel && (cmd == `DDAC_CMD_UPD || cmd == `DDAC_CMD_WR_UPD))
				|| cmd == `DDAC_CMD_WR_IN_UPD_ALL);

			// clear has priority: zero scale in both stages [RQ9] [RQ11]
			always_ff @(posedge clock)
			begin
				if (rst || clr_fall)
				begin
					in_reg[ch] <= `DDAC_ZERO_CODE;
					dac_reg[ch] <= `DDAC_ZERO_CODE;
					pending[ch] <= 1'b0;
				end
				else
				begin
					if (wr_in)
						in_reg[ch] <= code;
					if (upd)
					begin
						dac_reg[ch] <= wr_in ? code : in_reg[ch];
						pending[ch] <= 1'b0;
					end
					else if (wr_in && ld_ok)
						dac_reg[ch] <= code; // tied-low strobe passes new data straight through
					else if (wr_in)
						pending[ch] <= 1'b1;
					else if (ld_ok && pending[ch])
					begin
						dac_reg[ch] <= in_reg[ch]; // [RQ7]
						pending[ch] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// unsigned binary codes drive the outputs directly [RQ15]
	assign channel_a_out = dac_reg[0];
	assign channel_b_out = dac_reg[1];

	// ************************************************
	// clear mode and reference select
	// ************************************************
	// set on clear edge, left at the next complete word [RQ12]
	always_ff @(posedge clock)
	begin
		if (rst)
			clear_mode <= 1'b0;
		else if (clr_fall)
			clear_mode <= 1'b1;
		else if (word_ok)
			clear_mode <= 1'b0;
	end

	// external reference by default; data bit 0 of the reference command turns it on [RQ14]
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			internal_ref_on <= 1'b0;
			reference_pin_oe <= 1'b0;
		end
		else if (word_ok && cmd == `DDAC_CMD_REF)
		begin
			internal_ref_on <= shift[0];
			reference_pin_oe <= shift[0];
		end
	end
endmodule : ddac_core
`default_nettype wire

// ---- verif/ddac_core_chk.sv ----
// port checker for the converter front end
`timescale 1ns/100ps
`default_nettype none
module ddac_core_chk
(
	// watched ports
	input wire logic clock,
	input wire logic rst,
	input wire logic frame_sel_n,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic load_outputs_n,
	input wire logic async_clear_n,
	input wire logic [15:0] channel_a_out,
	input wire logic [15:0] channel_b_out,
	input wire logic clear_mode,
	input wire logic internal_ref_on,
	input wire logic reference_pin_oe
);
	// ****************
	// assertions
	// ****************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_REF_IN: assert property (!internal_ref_on |-> !reference_pin_oe)
		else $error("ref pin driven");
	AST_IDLE: assert property ((frame_sel_n && load_outputs_n && async_clear_n) [*8]
		|=> $stable({channel_a_out, channel_b_out})) else $error("idle change");
	AST_CLR: assert property ($fell(async_clear_n)
		|-> ##[1:6] (clear_mode && channel_a_out == 16'h0)) else $error("slow clear");
	AST_CLR_HOLD: assert property (!async_clear_n [*6] |=> $stable(channel_a_out))
		else $error("load in clear");
	AST_ZERO: assert property ($rose(clear_mode) |-> ##[0:1] channel_b_out == 16'h0)
		else $error("not zeroed");
	AST_MODE_END: assert property ($fell(clear_mode) |-> !$past(frame_sel_n, 4))
		else $error("mode end");
	AST_MODE_STAY: assert property ((clear_mode && frame_sel_n) [*8] |=> clear_mode)
		else $error("mode lost");
	AST_REF_CHG: assert property ($changed(internal_ref_on) |-> !$past(frame_sel_n, 4))
		else $error("ref change");
endmodule : ddac_core_chk
bind ddac_core ddac_core_chk chk (.*);
`default_nettype wire

// ---- verif/ddac_host.sv ----
// host model driving the serial link
`timescale 1ns/100ps
`default_nettype none
module ddac_host
(
	// serial link
	output var logic frame_sel_n,
	output var logic serial_clk,
	output var logic serial_data
);
	// link idles with clock still
	initial
	begin
		frame_sel_n = 1'b1;
		serial_clk = 1'b1;
		serial_data = 1'b0;
	end
	// msb first, 125 ns bit period, select low throughout
	task automatic send(input logic [23:0] w, input int n);
		frame_sel_n = 1'b0;
		for (int i = 23; i > 23 - n; i--)
		begin
			serial_data = w[i];
			#62.5 serial_clk = 1'b0;
			#62.5 serial_clk = 1'b1;
		end
		// released data flips so a stale bit cannot pass
		#62.5 serial_data = ~serial_data;
		frame_sel_n = 1'b1;
		#62.5;
	endtask : send
endmodule : ddac_host
`default_nettype wire

// ---- verif/tb_ddac_core.sv ----
// bench for the converter front end
`timescale 1ns/100ps
`default_nettype none
module tb_ddac_core;
	logic clock = 0, rst = 1, load_outputs_n = 1, async_clear_n = 1;
	wire logic frame_sel_n, serial_clk, serial_data;
	logic [15:0] channel_a_out, channel_b_out;
	logic clear_mode, internal_ref_on, reference_pin_oe;
	int miscompares = 0, compares = 0, cycles = 0;
	// ****************
	// harness
	// ****************
	always #4 clock = ~clock;
	ddac_host host (.frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_data(serial_data));
	ddac_core DUT (.clock(clock), .rst(rst), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
		.serial_data(serial_data), .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
		.channel_a_out(channel_a_out), .channel_b_out(channel_b_out), .clear_mode(clear_mode),
		.internal_ref_on(internal_ref_on), .reference_pin_oe(reference_pin_oe));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one word, then time for the output to settle
	task automatic snd(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d, input int n = 24);
		host.send({2'h0, c, a, d}, n);
		repeat (4) @(negedge clock);
	endtask : snd
	task automatic pulse(input bit clr);
		@(negedge clock);
		if (clr) async_clear_n = 1'b0;
		else load_outputs_n = 1'b0;
		repeat (8) @(negedge clock);
		load_outputs_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask : pulse
	// ****************
	// scenarios
	// ****************
	task automatic t_write;
		chk("ref", 16'h0, {14'h0, internal_ref_on, reference_pin_oe});
		snd(3'h3, 3'h0, 16'ha5c3);
		chk("a", 16'ha5c3, channel_a_out);
		snd(3'h2, 3'h7, 16'hffff);
		chk("b", 16'hffff, channel_b_out);
		snd(3'h3, 3'h1, 16'h1234, 23);
		chk("b", 16'hffff, channel_b_out);
		snd(3'h3, 3'h1, 16'h0f0f);
		chk("b", 16'h0f0f, channel_b_out);
		snd(3'h7, 3'h0, 16'h1);
		chk("ref", 16'h3, {14'h0, internal_ref_on, reference_pin_oe});
	endtask : t_write
	task automatic t_load;
		snd(3'h0, 3'h0, 16'h1111);
		snd(3'h0, 3'h1, 16'h2222);
		chk("a", 16'hffff, channel_a_out);
		pulse(0);
		chk("a", 16'h1111, channel_a_out);
		chk("b", 16'h2222, channel_b_out);
		snd(3'h0, 3'h0, 16'h3333);
		snd(3'h1, 3'h0, 16'h0);
		chk("a", 16'h3333, channel_a_out);
		load_outputs_n = 1'b0;
		snd(3'h0, 3'h1, 16'h4444);
		chk("b", 16'h4444, channel_b_out);
		load_outputs_n = 1'b1;
	endtask : t_load
	task automatic t_clear;
		snd(3'h0, 3'h0, 16'h5555);
		pulse(1);
		chk("a", 16'h0, channel_a_out);
		chk("b", 16'h0, channel_b_out);
		async_clear_n = 1'b1;
		pulse(0);
		chk("a", 16'h0, channel_a_out);
		pulse(1);
		snd(3'h0, 3'h0, 16'h5a5a);
		pulse(0);
		chk("a", 16'h0, channel_a_out);
		async_clear_n = 1'b1;
		pulse(0);
		chk("a", 16'h5a5a, channel_a_out);
		fork
			snd(3'h3, 3'h0, 16'h6666);
			pulse(1);
		join
		async_clear_n = 1'b1;
		chk("mode", 16'h1, {15'h0, clear_mode});
		chk("a", 16'h0, channel_a_out);
		snd(3'h3, 3'h0, 16'h7777);
		chk("a", 16'h7777, channel_a_out);
		chk("mode", 16'h0, {15'h0, clear_mode});
	endtask : t_clear
	task automatic conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	// hang guard, well above the run of about 6000 cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			miscompares++;
			conclude;
		end
	end
	initial
	begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		t_write;
		t_load;
		t_clear;
		conclude;
	end
endmodule : tb_ddac_core
`default_nettype wire
